// File: acs_pkg.sv
// Purpose: shared constants and types of the conversion sequencer
// Assumes: byte-wide control registers and 10-bit results carried on a 16-bit plain register port
// Notes:   offsets are register indices on the plain port
package acs_pkg;

    // ****************************************************************
    // bus and field layout
    // ****************************************************************
    localparam int unsigned ACS_AW       = 5;
    localparam int unsigned ACS_DW       = 16;
    localparam logic [4:0]  ACS_OFS_CSR  = 5'h00;
    localparam logic [4:0]  ACS_OFS_CR1  = 5'h01;
    localparam logic [4:0]  ACS_OFS_CR2  = 5'h02;
    localparam logic [4:0]  ACS_OFS_CR3  = 5'h03;
    localparam logic [4:0]  ACS_OFS_DR   = 5'h04;
    localparam logic [4:0]  ACS_OFS_DB   = 5'h10;
    localparam int unsigned ACS_IE_BIT   = 5;
    localparam int unsigned ACS_DONE_BIT = 7;
    localparam int unsigned ACS_PWR_BIT  = 0;
    localparam int unsigned ACS_REPEAT_BIT = 1;
    localparam int unsigned ACS_DIV_LSB  = 4;
    localparam int unsigned ACS_SCAN_BIT = 1;
    localparam int unsigned ACS_OVERRUN_BIT = 6;
    localparam int unsigned ACS_BUFEN_BIT   = 7;

    // ****************************************************************
    // converter constants
    // ****************************************************************
    localparam int unsigned ACS_RES_W     = 10;
    localparam int unsigned ACS_NUM_CH    = 16;
    localparam int unsigned ACS_BUF_DEPTH = 10;
    localparam logic [3:0]  ACS_SKIP_CH   = 4'hc;
    localparam logic [3:0]  ACS_LAST_CYC  = 4'hd;
    localparam logic [3:0]  ACS_SAMPLE    = 4'h4;
    localparam logic [9:0]  ACS_SAR_INIT  = 10'h200;
    localparam logic [4:0]  ACS_DIV0      = 5'h02;
    localparam logic [4:0]  ACS_DIV1      = 5'h03;
    localparam logic [4:0]  ACS_DIV2      = 5'h04;
    localparam logic [4:0]  ACS_DIV3      = 5'h06;
    localparam logic [4:0]  ACS_DIV4      = 5'h08;
    localparam logic [4:0]  ACS_DIV5      = 5'h0a;
    localparam logic [4:0]  ACS_DIV6      = 5'h0c;
    localparam logic [4:0]  ACS_DIV7      = 5'h12;

    typedef enum logic [1:0] {ACS_OFF, ACS_STAB, ACS_READY, ACS_CONV} acs_state_e;

    function automatic logic [4:0] acs_div_factor(input logic [2:0] sel);
        logic [4:0] f;
        unique case (sel)
            3'h0: f = ACS_DIV0;
            3'h1: f = ACS_DIV1;
            3'h2: f = ACS_DIV2;
            3'h3: f = ACS_DIV3;
            3'h4: f = ACS_DIV4;
            3'h5: f = ACS_DIV5;
            3'h6: f = ACS_DIV6;
            3'h7: f = ACS_DIV7;
        endcase
        return f;
    endfunction : acs_div_factor

endpackage : acs_pkg

// File: acs_sequencer.sv
// Purpose: control and sequencing of a 10-bit successive-approximation converter
// Assumes: comp_i is the analog comparator, settled within one master cycle
// Notes:   single, continuous, buffered, single-scan and continuous-scan modes
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module acs_sequencer #(
    parameter int unsigned BUF_DEPTH = acs_pkg::ACS_BUF_DEPTH
) (
    input  wire logic                       clock_i,
    input  wire logic                       rst_i,
    input  wire logic                       ce_i,
    input  wire logic [acs_pkg::ACS_AW-1:0] addr_i,
    input  wire logic [acs_pkg::ACS_DW-1:0] wdata_i,
    input  wire logic                       wr_i,
    input  wire logic                       rd_i,
    output logic      [acs_pkg::ACS_DW-1:0] rdata_o,
    input  wire logic                       comp_i,
    output logic [acs_pkg::ACS_RES_W-1:0]   dac_code_o,
    output logic                      [3:0] mux_sel_o,
    output logic [acs_pkg::ACS_NUM_CH-1:0]  pin_disable_o,
    output logic                            powered_o,
    output logic                            conv_start_o,
    output logic                            irq_o
);
    import acs_pkg::*;

    // ****************************************************************
    // declarations
    // ****************************************************************
    acs_state_e             state_ff;
    acs_state_e             nxt_state;
    logic                   pwr_ff;
    logic                   repeat_ff;
    logic                   scan_ff;
    logic                   bufen_ff;
    logic                   ie_ff;
    logic                   done_ff;
    logic                   overrun_ff;
    logic                   irq_ff;
    logic                   start_ff;
    logic                   pend_ff;
    logic [2:0]             div_sel_ff;
    logic [4:0]             div_cnt_ff;
    logic [3:0]             ch_ff;
    logic [3:0]             last_ch_ff;
    logic [3:0]             cyc_ff;
    logic [3:0]             stab_ff;
    logic [3:0]             bidx_ff;
    logic [ACS_RES_W-1:0]   dac_ff;
    logic [ACS_RES_W-1:0]   dr_ff;
    logic [ACS_RES_W-1:0]   sar_nxt;
    logic [ACS_RES_W-1:0]   buf_mem [ACS_NUM_CH];
    logic [ACS_NUM_CH-1:0]  unread_ff;
    logic [ACS_NUM_CH-1:0]  pin_dis_ff;
    logic [ACS_DW-1:0]      rdata_ff;
    logic [ACS_DW-1:0]      rd_val;
    logic                   wr_csr;
    logic                   wr_cr1;
    logic                   wr_cr2;
    logic                   wr_cr3;
    logic                   rd_db;
    logic                   start_wr;
    logic                   wake_wr;
    logic                   off_wr;
    logic                   tick;
    logic                   conv_end;
    logic                   restart;
    logic                   go;
    logic                   fresh;
    logic                   keep_going;
    logic                   buffered;
    logic                   pass_last;
    logic                   done_evt;
    logic                   buf_we;
    logic [3:0]             buf_idx;
    logic [3:0]             next_ch;
    logic [3:0]             bitpos;

    // ****************************************************************
    // register port decode
    // ****************************************************************
    assign wr_csr   = ce_i && wr_i && (addr_i == ACS_OFS_CSR);
    assign wr_cr1   = ce_i && wr_i && (addr_i == ACS_OFS_CR1);
    assign wr_cr2   = ce_i && wr_i && (addr_i == ACS_OFS_CR2);
    assign wr_cr3   = ce_i && wr_i && (addr_i == ACS_OFS_CR3);
    assign rd_db    = ce_i && rd_i && (addr_i >= ACS_OFS_DB);
    assign wake_wr  = wr_cr1 && wdata_i[ACS_PWR_BIT] && !pwr_ff;
    assign start_wr = wr_cr1 && wdata_i[ACS_PWR_BIT] && pwr_ff;
    assign off_wr   = wr_cr1 && !wdata_i[ACS_PWR_BIT];

    // ****************************************************************
    // sequencing decisions
    // ****************************************************************
    assign tick      = ce_i && pwr_ff && (div_cnt_ff == acs_div_factor(div_sel_ff) - 5'h01);
    assign conv_end  = ce_i && (state_ff == ACS_CONV) && tick && (cyc_ff == ACS_LAST_CYC);
    assign buffered  = bufen_ff && repeat_ff && !scan_ff;
    // channel twelve is never part of a scan pass
    assign next_ch   = (ch_ff + 4'h1 == ACS_SKIP_CH) ? ch_ff + 4'h2 : ch_ff + 4'h1;
    assign pass_last = (ch_ff >= last_ch_ff) || (next_ch > last_ch_ff);
    // a change on the finishing edge only steers the next conversion
    assign restart   = wr_csr && (state_ff == ACS_CONV) && !scan_ff
                       && (wdata_i[3:0] != ch_ff) && !conv_end;
    assign keep_going = scan_ff ? (!pass_last || repeat_ff) : repeat_ff;
    assign done_evt  = conv_end && (scan_ff ? pass_last
                       : (buffered ? (bidx_ff == 4'(BUF_DEPTH - 1)) : 1'b1));
    assign buf_we    = conv_end && (scan_ff || buffered) && (ch_ff != ACS_SKIP_CH);
    assign buf_idx   = scan_ff ? ch_ff : bidx_ff;
    assign fresh     = go && (state_ff != ACS_CONV);

    always_comb
    begin
        nxt_state = state_ff;
        go        = 1'b0;
        unique case (state_ff)
            ACS_OFF:
            begin
                if (wake_wr)
                begin
                    nxt_state = ACS_STAB;
                end
            end
            ACS_STAB:
            begin
                if (tick && (stab_ff == ACS_LAST_CYC))
                begin
                    nxt_state = (pend_ff || start_wr) ? ACS_CONV : ACS_READY;
                    go        = pend_ff || start_wr;
                end
            end
            ACS_READY:
            begin
                if (start_wr)
                begin
                    nxt_state = ACS_CONV;
                    go        = 1'b1;
                end
            end
            ACS_CONV:
            begin
                if (restart)
                begin
                    go = 1'b1;
                end
                else if (conv_end)
                begin
                    go        = keep_going;
                    nxt_state = keep_going ? ACS_CONV : ACS_READY;
                end
            end
        endcase
        if (off_wr)
        begin
            nxt_state = ACS_OFF;
            go        = 1'b0;
        end
    end

    // successive approximation: keep the tested bit by comparator, try the next one
    assign bitpos = ACS_LAST_CYC - cyc_ff;

    always_comb
    begin
        sar_nxt = dac_ff;
        if (cyc_ff >= ACS_SAMPLE)
        begin
            sar_nxt[bitpos] = comp_i;
            if (bitpos != 4'h0)
            begin
                sar_nxt[bitpos - 4'h1] = 1'b1;
            end
        end
    end

    // ****************************************************************
    // state and converter timing
    // ****************************************************************
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            state_ff <= ACS_OFF;
        end
        else if (ce_i)
        begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            div_cnt_ff <= 5'h00;
        end
        else if (ce_i)
        begin
            if (!pwr_ff || go || tick)
            begin
                div_cnt_ff <= 5'h00;
            end
            else
            begin
                div_cnt_ff <= div_cnt_ff + 5'h01;
            end
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            stab_ff <= 4'h0;
            pend_ff <= 1'b0;
        end
        else if (ce_i)
        begin
            if (wake_wr)
            begin
                stab_ff <= 4'h0;
            end
            else if ((state_ff == ACS_STAB) && tick)
            begin
                stab_ff <= stab_ff + 4'h1;
            end
            pend_ff <= (state_ff == ACS_STAB) && !off_wr && (pend_ff || start_wr);
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            cyc_ff   <= 4'h0;
            dac_ff   <= ACS_SAR_INIT;
            start_ff <= 1'b0;
        end
        else if (ce_i)
        begin
            start_ff <= go;
            if (go)
            begin
                cyc_ff <= 4'h0;
                dac_ff <= ACS_SAR_INIT;
            end
            else if ((state_ff == ACS_CONV) && tick)
            begin
                cyc_ff <= cyc_ff + 4'h1;
                dac_ff <= sar_nxt;
            end
        end
    end

    // ****************************************************************
    // control registers
    // ****************************************************************
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            pwr_ff     <= 1'b0;
            repeat_ff  <= 1'b0;
            div_sel_ff <= 3'h0;
            scan_ff    <= 1'b0;
            bufen_ff   <= 1'b0;
            ie_ff      <= 1'b0;
        end
        else if (ce_i)
        begin
            if (wr_cr1)
            begin
                pwr_ff     <= wdata_i[ACS_PWR_BIT];
                repeat_ff  <= wdata_i[ACS_REPEAT_BIT];
                div_sel_ff <= wdata_i[ACS_DIV_LSB +: 3];
            end
            if (wr_cr2)
            begin
                scan_ff <= wdata_i[ACS_SCAN_BIT];
            end
            if (wr_cr3)
            begin
                bufen_ff <= wdata_i[ACS_BUFEN_BIT];
            end
            if (wr_csr)
            begin
                ie_ff <= wdata_i[ACS_IE_BIT];
            end
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            ch_ff      <= 4'h0;
            last_ch_ff <= 4'h0;
        end
        else if (ce_i)
        begin
            if (wr_csr)
            begin
                last_ch_ff <= wdata_i[3:0];
            end
            else if (fresh && scan_ff)
            begin
                last_ch_ff <= ch_ff;
            end
            if (wr_csr && !(scan_ff && (state_ff == ACS_CONV)))
            begin
                ch_ff <= wdata_i[3:0];
            end
            else if (fresh && scan_ff)
            begin
                ch_ff <= 4'h0;
            end
            else if (conv_end && scan_ff && !off_wr)
            begin
                ch_ff <= !pass_last ? next_ch : (repeat_ff ? 4'h0 : last_ch_ff);
            end
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            done_ff <= 1'b0;
            overrun_ff <= 1'b0;
            irq_ff  <= 1'b0;
        end
        else if (ce_i)
        begin
            if (done_evt)
            begin
                done_ff <= 1'b1;
            end
            else if (wr_csr && !wdata_i[ACS_DONE_BIT])
            begin
                done_ff <= 1'b0;
            end
            if (buf_we && unread_ff[buf_idx])
            begin
                overrun_ff <= 1'b1;
            end
            else if (start_wr || wake_wr || (wr_cr3 && !wdata_i[ACS_OVERRUN_BIT]))
            begin
                overrun_ff <= 1'b0;
            end
            irq_ff <= done_ff && ie_ff;
        end
    end

    // ****************************************************************
    // result storage
    // ****************************************************************
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            dr_ff   <= '0;
            bidx_ff <= 4'h0;
        end
        else if (ce_i)
        begin
            if (conv_end && !buf_we)
            begin
                dr_ff <= sar_nxt;
            end
            if (fresh)
            begin
                bidx_ff <= 4'h0;
            end
            else if (conv_end && buffered)
            begin
                bidx_ff <= (bidx_ff == 4'(BUF_DEPTH - 1)) ? 4'h0 : bidx_ff + 4'h1;
            end
        end
    end

    for (genvar g = 0; g < ACS_NUM_CH; g++)
    begin : g_ch
        always_ff @(posedge clock_i)
        begin
            if (rst_i)
            begin
                unread_ff[g]  <= 1'b0;
                pin_dis_ff[g] <= 1'b0;
                buf_mem[g]    <= '0;
            end
            else if (ce_i)
            begin
                pin_dis_ff[g] <= pwr_ff && (ch_ff == 4'(g));
                if (buf_we && (buf_idx == 4'(g)))
                begin
                    buf_mem[g]   <= sar_nxt;
                    unread_ff[g] <= 1'b1;
                end
                else if (rd_db && (addr_i[3:0] == 4'(g)))
                begin
                    unread_ff[g] <= 1'b0;
                end
            end
        end
    end

    // ****************************************************************
    // read port
    // ****************************************************************
    always_comb
    begin
        rd_val = '0;
        if (rd_db)
        begin
            rd_val[ACS_RES_W-1:0] = buf_mem[addr_i[3:0]];
        end
        else
        begin
            unique case (addr_i)
                ACS_OFS_CSR: rd_val[7:0] = {done_ff, 1'b0, ie_ff, 1'b0, ch_ff};
                ACS_OFS_CR1: rd_val[7:0] = {1'b0, div_sel_ff, 2'b00, repeat_ff, pwr_ff};
                ACS_OFS_CR2: rd_val[7:0] = {6'h00, scan_ff, 1'b0};
                ACS_OFS_CR3: rd_val[7:0] = {bufen_ff, overrun_ff, 6'h00};
                ACS_OFS_DR:  rd_val[ACS_RES_W-1:0] = dr_ff;
                default:     rd_val = '0;
            endcase
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            rdata_ff <= '0;
        end
        else if (ce_i)
        begin
            rdata_ff <= rd_i ? rd_val : '0;
        end
    end

    assign rdata_o       = rdata_ff;
    assign dac_code_o    = dac_ff;
    assign mux_sel_o     = ch_ff;
    assign pin_disable_o = pin_dis_ff;
    assign powered_o     = pwr_ff;
    assign conv_start_o  = start_ff;
    assign irq_o         = irq_ff;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);

    sequence s_wake;
        wake_wr ##1 (state_ff == ACS_STAB) && !conv_start_o;
    endsequence

    property p_wake_only;
        (state_ff == ACS_OFF) && wake_wr |-> s_wake;
    endproperty
    a_wake_only: assert property (p_wake_only) else $error("wake started a conversion");

    property p_power_off;
        off_wr |=> (state_ff == ACS_OFF) && !pwr_ff;
    endproperty
    a_power_off: assert property (p_power_off) else $error("power-off not taken");

    property p_pin_disable;
        ce_i |=> pin_disable_o == ($past(pwr_ff) ? (16'h0001 << $past(ch_ff)) : 16'h0000);
    endproperty
    a_pin_disable: assert property (p_pin_disable) else $error("pin disable wrong");

    property p_single_done;
        conv_end && !scan_ff && !repeat_ff && !off_wr
            |=> done_ff && (state_ff == ACS_READY) && (dr_ff == $past(sar_nxt));
    endproperty
    a_single_done: assert property (p_single_done) else $error("single result lost");

    property p_ovr_clear;
        start_wr && !buf_we |=> !overrun_ff;
    endproperty
    a_ovr_clear: assert property (p_ovr_clear) else $error("overrun not cleared");

    property p_scan_start;
        fresh && scan_ff |=> (ch_ff == 4'h0) ##1 conv_start_o == 1'b0;
    endproperty
    a_scan_start: assert property (p_scan_start) else $error("scan not at channel 0");

    property p_restart;
        restart && !off_wr |=> conv_start_o && (cyc_ff == 4'h0) && (dac_ff == ACS_SAR_INIT);
    endproperty
    a_restart: assert property (p_restart) else $error("channel change no restart");

    property p_irq;
        ce_i && done_ff && ie_ff |=> irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing");

    property p_overrun;
        buf_we && unread_ff[buf_idx] |=> overrun_ff;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun missed");

endmodule : acs_sequencer

`default_nettype wire

// File: acs_analog_model.sv
// Purpose: analog inputs and comparator at the far side of the sequencer
// Assumes: channel c holds level {c, c, 2'b01}
// Notes:   answers in the same cycle as the trial code
`timescale 1ns/1ps
`default_nettype none
module acs_analog_model (
    input  wire logic [3:0] mux_sel_i,
    input  wire logic [9:0] dac_code_i,
    output logic            comp_o
);
    logic [9:0] level;
    assign level  = {mux_sel_i, mux_sel_i, 2'b01};
    assign comp_o = (level >= dac_code_i);
endmodule : acs_analog_model
`default_nettype wire

// File: test_adc_conversion_sequencer.sv
// Purpose: self-checking bench of the conversion sequencer
// Assumes: analog model levels follow the channel number
// Notes:   random channels, and divide selects after the first pass (fixed at 7), from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module test_adc_conversion_sequencer;
    import acs_pkg::*;
    logic        clock_i = 1'b0, rst_i = 1'b1, wr = 1'b0, rd = 1'b0, comp, pwr, cst, irq;
    logic [4:0]  addr = 5'h00;
    logic [15:0] wdata = 16'h0000, rdata, got, pdis;
    logic [9:0]  dac;
    logic [3:0]  msel, ch;
    logic [2:0]  dv;
    int          err_count = 0, compares = 0, seed = 32'h65caad7f, n, f;
    always #2.5 clock_i = ~clock_i;
    acs_sequencer dut_u (.clock_i(clock_i), .rst_i(rst_i), .ce_i(1'b1), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .comp_i(comp),
        .dac_code_o(dac), .mux_sel_o(msel), .pin_disable_o(pdis), .powered_o(pwr),
        .conv_start_o(cst), .irq_o(irq));
    acs_analog_model ana_u (.mux_sel_i(msel), .dac_code_i(dac), .comp_o(comp));
    function automatic logic [15:0] lvl(input logic [3:0] c);
        return {6'h00, c, c, 2'b01};
    endfunction : lvl
    function automatic int fdiv(input logic [2:0] s);
        int t[8] = '{2, 3, 4, 6, 8, 10, 12, 18};
        return t[s];
    endfunction : fdiv
    task automatic give_verdict;
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e)
        begin
            err_count++;
            $display("FAIL %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic bus_wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clock_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock_i);
        wr <= 1'b0;
    endtask : bus_wr
    task automatic bus_rd(input logic [4:0] a);
        @(posedge clock_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock_i);
        rd <= 1'b0;
        #1 got = rdata;
    endtask : bus_rd
    task automatic wait_irq;
        n = 0;
        for (int i = 0; i < 4000 && irq !== 1'b1; i++)
        begin
            @(posedge clock_i);
            #1 n = (cst === 1'b1) ? 0 : n + 1;
        end
        if (irq !== 1'b1)
        begin
            err_count++;
            $display("FAIL %0t no interrupt", $time);
            give_verdict();
        end
    endtask : wait_irq
    initial
    begin
        repeat (6) @(posedge clock_i);
        rst_i <= 1'b0;
        #1 chk({13'h0, pwr, irq, cst}, 16'h0000);
        bus_rd(5'h07);
        chk(got, 16'h0000);
        for (int k = 0; k < 5; k++)
        begin
            ch = 4'($random(seed));
            dv = (k == 0) ? 3'h7 : 3'($random(seed));
            f = fdiv(dv);
            bus_wr(ACS_OFS_CSR, {12'h002, ch});
            bus_wr(ACS_OFS_CR1, {9'h0, dv, 4'h1});
            repeat (14 * f) @(posedge clock_i);
            bus_rd(ACS_OFS_CSR);
            chk(got, {12'h002, ch});
            bus_wr(ACS_OFS_CR1, {9'h0, dv, 4'h1});
            wait_irq();
            chk({15'h0, n >= 14 * f && n <= 14 * f + 2}, 16'h0001);
            chk(pdis, 16'h0001 << ch);
            bus_rd(ACS_OFS_DR);
            chk(got, lvl(ch));
            bus_wr(ACS_OFS_CSR, {12'h002, ch});
            bus_wr(ACS_OFS_CR1, 16'h0000);
            repeat (2) @(posedge clock_i);
            #1 chk(pdis, 16'h0000);
            chk({15'h0, pwr}, 16'h0000);
        end
        bus_wr(ACS_OFS_CSR, 16'h0025);
        bus_wr(ACS_OFS_CR1, 16'h0003);
        bus_wr(ACS_OFS_CR1, 16'h0003);
        wait_irq();
        bus_wr(ACS_OFS_CSR, 16'h0026);
        #1 chk({15'h0, cst}, 16'h0001);
        bus_rd(ACS_OFS_DR);
        chk(got, lvl(4'h5));
        wait_irq();
        bus_rd(ACS_OFS_DR);
        chk(got, lvl(4'h6));
        bus_wr(ACS_OFS_CR1, 16'h0001);
        repeat (40) @(posedge clock_i);
        bus_wr(ACS_OFS_CSR, 16'h0026);
        repeat (40) @(posedge clock_i);
        bus_rd(ACS_OFS_CSR);
        chk(got, 16'h0026);
        bus_wr(ACS_OFS_CR3, 16'h0080);
        bus_wr(ACS_OFS_CR1, 16'h0003);
        wait_irq();
        bus_rd(ACS_OFS_DB + 5'h09);
        chk(got, lvl(4'h6));
        repeat (40) @(posedge clock_i);
        bus_rd(ACS_OFS_CR3);
        chk(got, 16'h00c0);
        bus_wr(ACS_OFS_CR1, 16'h0000);
        bus_wr(ACS_OFS_CR3, 16'h0000);
        bus_wr(ACS_OFS_CR2, 16'h0002);
        bus_wr(ACS_OFS_CSR, 16'h0023);
        bus_wr(ACS_OFS_CR1, 16'h0001);
        bus_wr(ACS_OFS_CR1, 16'h0001);
        wait_irq();
        for (int c = 0; c < 4; c++)
        begin
            bus_rd(ACS_OFS_DB + 5'(c));
            chk(got, lvl(4'(c)));
        end
        bus_rd(ACS_OFS_CSR);
        chk(got, 16'h00a3);
        repeat (2)
        begin
            bus_wr(ACS_OFS_CSR, 16'h0023);
            bus_wr(ACS_OFS_CR1, 16'h0001);
            wait_irq();
        end
        bus_rd(ACS_OFS_CR3);
        chk(got & 16'h0040, 16'h0040);
        bus_wr(ACS_OFS_CR1, 16'h0001);
        bus_rd(ACS_OFS_CR3);
        chk(got & 16'h0040, 16'h0000);
        bus_wr(ACS_OFS_CR1, 16'h0000);
        #1 chk({15'h0, pwr}, 16'h0000);
        bus_wr(ACS_OFS_CSR, 16'h0023);
        bus_wr(ACS_OFS_CR1, 16'h0003);
        bus_wr(ACS_OFS_CR1, 16'h0003);
        wait_irq();
        bus_rd(ACS_OFS_CSR);
        chk(got, 16'h00a0);
        bus_wr(ACS_OFS_CR1, 16'h0000);
        repeat (2) @(posedge clock_i);
        #1 chk({14'h0, cst, pwr}, 16'h0000);
        give_verdict();
    end
endmodule : test_adc_conversion_sequencer
`default_nettype wire
